// ### rtl/mwn_decode.sv
// decode and execute of move-accumulator-to-file and no-operation
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - top bits 0000001 select move, low seven address
// - move writes accumulator to file, flags untouched
// - one cycle: decode, read, process, write in Q4
// - no-op is 000000 0xx00000, x ignored
// - no-op changes nothing but program counter
module mwn_decode (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [13:0] instr_i,
	input wire logic [7:0] acc_i,
	output logic [1:0] phase_o,
	output logic pc_inc_o,
	output logic file_rd_o,
	output logic [6:0] file_addr_o,
	output logic file_we_o,
	output logic [7:0] file_wdata_o,
	output logic status_we_o,
	output logic acc_we_o,
	output logic is_move_o,
	output logic is_nop_o,
	output logic illegal_o
);
	mwn_pkg::mwn_phase_e phase;
	logic cycle_end;

	mwn_phase_gen u_phase (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.phase_o(phase),
		.cycle_end_o(cycle_end)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode latched in Q1
	logic dec_move, dec_nop;
	logic is_move_q, is_move_d;
	logic is_nop_q, is_nop_d;
	logic illegal_q, illegal_d;
	logic [6:0] addr_q, addr_d;

	assign dec_move = (instr_i[13:7] == mwn_pkg::MOVE_ACC_TO_FILE_TOP);
	assign dec_nop = ((instr_i & mwn_pkg::NO_OPERATION_OP_MASK)
		== mwn_pkg::NO_OPERATION_OP_VAL);

	always_comb begin
		is_move_d = is_move_q;
		is_nop_d = is_nop_q;
		illegal_d = illegal_q;
		addr_d = addr_q;
		if (phase == mwn_pkg::MWN_Q1) begin
			is_move_d = dec_move;
			is_nop_d = dec_nop;
			illegal_d = !dec_move && !dec_nop;
			// a no-op leaves the last move address standing
			addr_d = dec_move ? instr_i[6:0] : addr_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			is_move_q <= 1'b0;
			is_nop_q <= 1'b0;
			illegal_q <= 1'b0;
			addr_q <= mwn_pkg::ADDR_RESET;
		end else begin
			is_move_q <= is_move_d;
			is_nop_q <= is_nop_d;
			illegal_q <= illegal_d;
			addr_q <= addr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// write data captured at the end of Q3
	logic [7:0] wdata_q, wdata_d;

	always_comb begin
		wdata_d = wdata_q;
		if (phase == mwn_pkg::MWN_Q3 && is_move_q) begin
			wdata_d = acc_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wdata_q <= mwn_pkg::DATA_RESET;
		end else begin
			wdata_q <= wdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign phase_o = phase;
	assign pc_inc_o = cycle_end;
	assign file_rd_o = is_move_q && (phase == mwn_pkg::MWN_Q2);
	assign file_we_o = is_move_q && (phase == mwn_pkg::MWN_Q4);
	assign file_addr_o = addr_q;
	assign file_wdata_o = wdata_q;
	assign status_we_o = 1'b0;
	assign acc_we_o = 1'b0;
	assign is_move_o = is_move_q;
	assign is_nop_o = is_nop_q;
	assign illegal_o = illegal_q;

	////////////////////////////////////////////////////////////////////////////
	// checks: phase sequence
	a_phase_q1_q2: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 |=> phase == mwn_pkg::MWN_Q2)
		else $error("phase after Q1 wrong");
	a_phase_q2_q3: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q2 |=> phase == mwn_pkg::MWN_Q3)
		else $error("phase after Q2 wrong");
	a_phase_q3_q4: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q3 |=> phase == mwn_pkg::MWN_Q4)
		else $error("phase after Q3 wrong");
	a_phase_q4_q1: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q4 |=> phase == mwn_pkg::MWN_Q1)
		else $error("phase after Q4 wrong");
	a_reset_state: assert property (@(posedge clk_i)
		srst_i |=> phase == mwn_pkg::MWN_Q1 && !is_move_q && !is_nop_q
		&& !illegal_q && !file_we_o && !file_rd_o)
		else $error("reset state wrong");
	a_pc_in_q4: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q4 |-> pc_inc_o)
		else $error("no program counter step in Q4");
	a_pc_one_clock: assert property (@(posedge clk_i) disable iff (srst_i)
		pc_inc_o |=> !pc_inc_o)
		else $error("program counter step too long");

	////////////////////////////////////////////////////////////////////////////
	// checks: move
	a_move_write_q4: assert property (@(posedge clk_i) disable iff (srst_i)
		file_we_o |-> phase == mwn_pkg::MWN_Q4 && is_move_q)
		else $error("file write outside move Q4");
	a_write_one_clock: assert property (@(posedge clk_i) disable iff (srst_i)
		file_we_o |=> !file_we_o)
		else $error("file write too long");
	a_read_q2_only: assert property (@(posedge clk_i) disable iff (srst_i)
		file_rd_o |-> phase == mwn_pkg::MWN_Q2 && is_move_q)
		else $error("file read outside move Q2");
	a_rd_one_clock: assert property (@(posedge clk_i) disable iff (srst_i)
		file_rd_o |=> !file_rd_o)
		else $error("file read too long");
	a_move_addr: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 && dec_move |-> ##3 file_we_o
		&& file_addr_o == $past(instr_i[6:0], 3))
		else $error("move address wrong");
	a_move_data: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q3 && is_move_q |=> file_wdata_o == $past(acc_i))
		else $error("move data not accumulator");
	a_move_read_q2: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 && dec_move |=> file_rd_o ##1 !file_rd_o
		##1 file_we_o)
		else $error("move phase order wrong");
	a_move_pc: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 && dec_move |-> ##3 pc_inc_o ##1
		phase == mwn_pkg::MWN_Q1)
		else $error("move not one cycle");
	a_addr_held: assert property (@(posedge clk_i) disable iff (srst_i)
		!(phase == mwn_pkg::MWN_Q1 && dec_move) |=> $stable(file_addr_o))
		else $error("file address changed outside move decode");
	a_data_held: assert property (@(posedge clk_i) disable iff (srst_i)
		!(phase == mwn_pkg::MWN_Q3 && is_move_q) |=> $stable(file_wdata_o))
		else $error("write data changed outside move Q3");
	a_flags_kept: assert property (@(posedge clk_i) disable iff (srst_i)
		!status_we_o)
		else $error("status written");

	////////////////////////////////////////////////////////////////////////////
	// checks: no-op
	a_nop_decode: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 && instr_i[13:7] == 7'h00
		&& instr_i[4:0] == 5'h00 |=> is_nop_q)
		else $error("no-op missed");
	a_nop_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
		is_nop_q |-> !file_we_o && !file_rd_o && !acc_we_o)
		else $error("no-op touched state");
	a_nop_one_cycle: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 && dec_nop |-> ##3 pc_inc_o ##1
		phase == mwn_pkg::MWN_Q1)
		else $error("no-op not one cycle");
	a_nop_addr_kept: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 && dec_nop |=> $stable(file_addr_o))
		else $error("no-op changed file address");
	a_nop_data_kept: assert property (@(posedge clk_i) disable iff (srst_i)
		is_nop_q && phase == mwn_pkg::MWN_Q3 |=> $stable(file_wdata_o))
		else $error("no-op changed write data");
	a_status_nop: assert property (@(posedge clk_i) disable iff (srst_i)
		is_nop_q |-> !status_we_o && !acc_we_o)
		else $error("no-op wrote flags or accumulator");
	a_acc_kept: assert property (@(posedge clk_i) disable iff (srst_i)
		!acc_we_o)
		else $error("accumulator written");
	a_decode_excl: assert property (@(posedge clk_i) disable iff (srst_i)
		!(is_move_q && is_nop_q))
		else $error("move and no-op both decoded");

	////////////////////////////////////////////////////////////////////////////
	// checks: other words
	a_illegal_decode: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 && !dec_move && !dec_nop
		|=> illegal_q && !is_move_q && !is_nop_q)
		else $error("unsupported word not flagged");
	a_illegal_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
		illegal_q |-> !file_we_o && !file_rd_o)
		else $error("unsupported word touched file");
	a_illegal_pc: assert property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 && !dec_move && !dec_nop |-> ##3 pc_inc_o)
		else $error("unsupported word stalled program counter");

	////////////////////////////////////////////////////////////////////////////
	// coverage
	c_move: cover property (@(posedge clk_i) disable iff (srst_i) file_we_o);
	c_nop: cover property (@(posedge clk_i) disable iff (srst_i)
		is_nop_q && pc_inc_o);
	c_nop_dc: cover property (@(posedge clk_i) disable iff (srst_i)
		phase == mwn_pkg::MWN_Q1 && dec_nop && instr_i[6:5] == 2'h3);
	c_illegal: cover property (@(posedge clk_i) disable iff (srst_i)
		illegal_q && pc_inc_o);
	c_move_top: cover property (@(posedge clk_i) disable iff (srst_i)
		file_we_o && file_addr_o == 7'h7F);
endmodule : mwn_decode

// ### rtl/mwn_phase_gen.sv
// four-phase instruction cycle sequencer
`timescale 1ns/10ps
module mwn_phase_gen (
	input wire logic clk_i,
	input wire logic srst_i,
	output mwn_pkg::mwn_phase_e phase_o,
	output logic cycle_end_o
);
	mwn_pkg::mwn_phase_e phase_q, phase_d;

	always_comb begin
		unique case (phase_q)
			mwn_pkg::MWN_Q1: phase_d = mwn_pkg::MWN_Q2;
			mwn_pkg::MWN_Q2: phase_d = mwn_pkg::MWN_Q3;
			mwn_pkg::MWN_Q3: phase_d = mwn_pkg::MWN_Q4;
			mwn_pkg::MWN_Q4: phase_d = mwn_pkg::MWN_Q1;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			phase_q <= mwn_pkg::MWN_Q1;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign phase_o = phase_q;
	assign cycle_end_o = (phase_q == mwn_pkg::MWN_Q4);
endmodule : mwn_phase_gen

// ### rtl/mwn_pkg.sv
// package with encodings, phase type and widths for the move/no-op decoder
package mwn_pkg;
	localparam int unsigned INSTR_W = 14;
	localparam int unsigned ADDR_W = 7;
	localparam int unsigned DATA_W = 8;
	// upper seven bits of the move-accumulator-to-file word
	localparam logic [6:0] MOVE_ACC_TO_FILE_TOP = 7'h01;
	// no-operation: all bits zero except the two don't-care bits 6:5
	localparam logic [13:0] NO_OPERATION_OP_MASK = 14'h3F9F;
	localparam logic [13:0] NO_OPERATION_OP_VAL = 14'h0000;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	localparam logic [6:0] ADDR_RESET = 7'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	typedef enum logic [1:0] {
		MWN_Q1,
		MWN_Q2,
		MWN_Q3,
		MWN_Q4
	} mwn_phase_e;
endpackage : mwn_pkg

// ### testbench/move_w_and_nop_decode_test.sv
// self-checking bench for the move/no-op decoder
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module move_w_and_nop_decode_test;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [13:0] instr_i = 14'h0000;
	logic [7:0] acc_i = 8'h00;
	logic [1:0] phase_o;
	logic pc_inc_o, file_rd_o, file_we_o, status_we_o, acc_we_o;
	logic is_move_o, is_nop_o, illegal_o;
	logic [6:0] file_addr_o;
	logic [7:0] file_wdata_o;
	int miscompares = 0;
	int checks_done = 0;
	always #10 clk_i = ~clk_i;
	mwn_decode dut (.clk_i(clk_i), .srst_i(srst_i), .instr_i(instr_i), .acc_i(acc_i),
		.phase_o(phase_o), .pc_inc_o(pc_inc_o), .file_rd_o(file_rd_o),
		.file_addr_o(file_addr_o), .file_we_o(file_we_o), .file_wdata_o(file_wdata_o),
		.status_we_o(status_we_o), .acc_we_o(acc_we_o), .is_move_o(is_move_o),
		.is_nop_o(is_nop_o), .illegal_o(illegal_o));
	////////////////////////////////////////////////////////////////////////////////
	// one instruction cycle, entered in Q1; accumulator valid only in Q3
	task one_op(input logic [13:0] w, input logic [7:0] a, input logic mv, input logic np);
		instr_i = w;
		acc_i = ~a;
		@(posedge clk_i) #1;
		`CHK("rd", mv, file_rd_o)
		`CHK("dec", {mv, np, ~(mv | np)}, {is_move_o, is_nop_o, illegal_o})
		if (mv) `CHK("addr", w[6:0], file_addr_o)
		@(posedge clk_i) #1;
		acc_i = a;
		@(posedge clk_i) #1;
		acc_i = ~a;
		`CHK("we", {2'h3, mv}, {phase_o, file_we_o})
		`CHK("pc", 1'b1, pc_inc_o)
		`CHK("flags", 2'b00, {status_we_o, acc_we_o})
		if (mv) `CHK("data", a, file_wdata_o)
		@(posedge clk_i) #1;
		`CHK("wrap", 2'h0, phase_o)
	endtask : one_op
	task move_back_to_back;
		one_op({7'h01, 7'h00}, 8'hA5, 1'b1, 1'b0);
		one_op({7'h01, 7'h7F}, 8'h5A, 1'b1, 1'b0);
	endtask : move_back_to_back
	task nop_dont_care;
		for (int i = 0; i < 4; i++) begin
			one_op({7'h00, i[1:0], 5'h00}, 8'h3C, 1'b0, 1'b1);
		end
	endtask : nop_dont_care
	task near_miss;
		one_op(14'h0001, 8'hC3, 1'b0, 1'b0);
		one_op(14'h0100, 8'hC3, 1'b0, 1'b0);
	endtask : near_miss
	task reset_mid_run;
		instr_i = {7'h01, 7'h55};
		@(posedge clk_i) #1;
		srst_i = 1'b1;
		@(posedge clk_i) #1;
		`CHK("mid rst", 5'h00, {phase_o, file_we_o, file_rd_o, is_move_o})
		srst_i = 1'b0;
		one_op({7'h00, 7'h00}, 8'h11, 1'b0, 1'b1);
	endtask : reset_mid_run
	////////////////////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#5000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		#1;
		`CHK("rst", 3'b000, {phase_o, file_we_o})
		srst_i = 1'b0;
		move_back_to_back();
		nop_dont_care();
		near_miss();
		reset_mid_run();
		move_back_to_back();
		tally_and_finish();
	end
endmodule : move_w_and_nop_decode_test
